// ---- vtf_cfg.svh ----
`ifndef VTF_CFG_SVH
`define VTF_CFG_SVH

// ==========================================
// register indexes, byte address is four times the index
`define VTF_IDX_CTRL      8'h4C
`define VTF_IDX_HOST      8'h4D
`define VTF_IDX_LINE      8'h4E
`define VTF_IDX_HSYNC     8'h4F
`define VTF_IDX_ACT_START 8'h50
`define VTF_IDX_ACT_END   8'h51
`define VTF_IDX_FIELD     8'h52
`define VTF_IDX_VSYNC     8'h53
`define VTF_IDX_MSB       9
`define VTF_IDX_LSB       2
`define VTF_IDX_W         8

// ==========================================
// field layout and reset values
`define VTF_REG_W         16
`define VTF_CODE_W        6
`define VTF_CTRL_STRETCH  4
`define VTF_CTRL_HOSTSEL  1
`define VTF_HALF_BIT      0
`define VTF_CODE_CUSTOM   6'h3E
`define VTF_RESET_CODE    6'h00
`define VTF_RESET_REG     16'h0000
`define VTF_RESET_WORD    32'h0000_0000
`define VTF_RESP_OKAY     1'b0

`endif

// ---- vtf_pkg.sv ----
`include "vtf_cfg.svh"

package vtf_pkg;

	typedef struct packed
	{
		logic [`VTF_REG_W-1:0] lineClocks;
		logic [`VTF_REG_W-1:0] hsyncClocks;
		logic [`VTF_REG_W-1:0] activeStart;
		logic [`VTF_REG_W-1:0] activeEnd;
		logic [`VTF_REG_W-1:0] fieldLines;
		logic [`VTF_REG_W-1:0] vsyncLines;
	} vtf_timing_t;

	typedef enum logic [2:0]
	{
		VTF_IDLE = 3'b001,
		VTF_WAIT = 3'b010,
		VTF_DONE = 3'b100
	} vtf_state_t;

endpackage

// ---- vtf_top.sv ----
`timescale 1ns/10ps
`include "vtf_cfg.svh"

// Behaviour
// - stretch bit widens ten-field pulse to field
// - host select bit replaces pin standard code
// - six-bit host code register, resets zero
// - timing registers writable only in custom code
// - line length counts clocks per line
// - hsync width counts clocks of sync
// - sync start to first active sample
// - sync start to end of active
// - field lines with one half-line bit
// - half-line bit selects interlaced output
// - vsync length counts lines of sync
module vtf_top
(
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic [31:0]                   hrdata,
	output logic                          hresp,
	input  wire logic [`VTF_CODE_W-1:0]   pinStandardCode,
	input  wire vtf_pkg::vtf_timing_t     presetTiming,
	input  wire logic                     lineStart,
	input  wire logic                     fieldStart,
	input  wire logic                     tenFieldStart,
	output logic [`VTF_CODE_W-1:0]        activeStandardCode,
	output logic                          customMode,
	output logic                          interlaced,
	output logic [`VTF_REG_W-2:0]         wholeFieldLines,
	output vtf_pkg::vtf_timing_t          timing,
	output logic                          tenFieldIdPulse
);
	import vtf_pkg::*;

	// ==========================================
	// state

	vtf_state_t                 state_q;
	vtf_state_t                 state_d;
	logic [`VTF_IDX_W-1:0]      idx_q;
	logic                       wr_q;
	logic                       addrOk_q;
	logic [31:0]                hrdata_q;
	logic                       stretch_q;
	logic                       hostSel_q;
	logic [`VTF_CODE_W-1:0]     hostCode_q;
	logic [`VTF_CODE_W-1:0]     activeCode_q;
	logic                       custom_q;
	vtf_timing_t                timing_q;
	logic                       pulse_q;
	logic                       addrPhase;
	logic                       commit;
	logic [`VTF_CODE_W-1:0]     codeSel;
	logic [`VTF_REG_W-1:0]      wdata;
	logic [`VTF_REG_W-1:0]      rdMux;

	// decode of the captured index against one register
	function automatic logic hit(input logic [`VTF_IDX_W-1:0] idx, input logic [`VTF_IDX_W-1:0] reg_idx);
		hit = (idx == reg_idx);
	endfunction

	// ==========================================
	// ahb-lite slave, one wait state so read data comes from a flop

	assign addrPhase = ce && hsel && htrans[1] && hready;
	assign commit    = ce && (state_q == VTF_WAIT) && wr_q && addrOk_q;
	assign wdata     = hwdata[`VTF_REG_W-1:0];
	assign hreadyout = (state_q != VTF_WAIT);
	assign hrdata    = hrdata_q;
	assign hresp     = `VTF_RESP_OKAY;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			VTF_IDLE:
				if (addrPhase)
					state_d = VTF_WAIT;
			VTF_WAIT:
				state_d = VTF_DONE;
			VTF_DONE:
				if (addrPhase)
					state_d = VTF_WAIT;
				else
					state_d = VTF_IDLE;
			default:
				state_d = VTF_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_q <= VTF_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			idx_q    <= '0;
			wr_q     <= 1'b0;
			addrOk_q <= 1'b0;
		end
		else if (addrPhase && (state_q != VTF_WAIT))
		begin
			idx_q    <= haddr[`VTF_IDX_MSB:`VTF_IDX_LSB];
			wr_q     <= hwrite;
			// unaligned or out-of-window addresses read zero and drop writes
			addrOk_q <= (haddr[`VTF_IDX_LSB-1:0] == '0) && (haddr[31:`VTF_IDX_MSB+1] == '0);
		end
	end

	always_comb
	begin
		rdMux = `VTF_RESET_REG;
		if (addrOk_q)
		begin
			if (hit(idx_q, `VTF_IDX_CTRL))
			begin
				rdMux[`VTF_CTRL_STRETCH] = stretch_q;
				rdMux[`VTF_CTRL_HOSTSEL] = hostSel_q;
			end
			else if (hit(idx_q, `VTF_IDX_HOST))
				rdMux[`VTF_CODE_W-1:0] = hostCode_q;
			else if (hit(idx_q, `VTF_IDX_LINE))
				rdMux = timing_q.lineClocks;
			else if (hit(idx_q, `VTF_IDX_HSYNC))
				rdMux = timing_q.hsyncClocks;
			else if (hit(idx_q, `VTF_IDX_ACT_START))
				rdMux = timing_q.activeStart;
			else if (hit(idx_q, `VTF_IDX_ACT_END))
				rdMux = timing_q.activeEnd;
			else if (hit(idx_q, `VTF_IDX_FIELD))
				rdMux = timing_q.fieldLines;
			else if (hit(idx_q, `VTF_IDX_VSYNC))
				rdMux = timing_q.vsyncLines;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			hrdata_q <= `VTF_RESET_WORD;
		else if (ce && (state_q == VTF_WAIT))
			hrdata_q <= wr_q ? `VTF_RESET_WORD : {`VTF_RESET_REG, rdMux};
	end

	// ==========================================
	// control and host standard registers

	// reserved bits are not stored, so they read zero whatever was written
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stretch_q <= 1'b0;
			hostSel_q <= 1'b0;
		end
		else if (commit && hit(idx_q, `VTF_IDX_CTRL))
		begin
			stretch_q <= wdata[`VTF_CTRL_STRETCH];
			hostSel_q <= wdata[`VTF_CTRL_HOSTSEL];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			hostCode_q <= `VTF_RESET_CODE;
		else if (commit && hit(idx_q, `VTF_IDX_HOST))
			hostCode_q <= wdata[`VTF_CODE_W-1:0];
	end

	assign codeSel = hostSel_q ? hostCode_q : pinStandardCode;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			activeCode_q <= `VTF_RESET_CODE;
			custom_q     <= 1'b0;
		end
		else if (ce)
		begin
			activeCode_q <= codeSel;
			custom_q     <= (codeSel == `VTF_CODE_CUSTOM);
		end
	end

	assign activeStandardCode = activeCode_q;
	assign customMode         = custom_q;

	// ==========================================
	// timing parameter registers

	// preset values follow the active format every enabled cycle outside custom mode
	// software writes land only in custom mode
	always_ff @(posedge clk)
	begin
		if (rst)
			timing_q <= '0;
		else if (ce && !custom_q)
			timing_q <= presetTiming;
		else if (commit)
		begin
			if (hit(idx_q, `VTF_IDX_LINE))
				timing_q.lineClocks <= wdata;
			if (hit(idx_q, `VTF_IDX_HSYNC))
				timing_q.hsyncClocks <= wdata;
			if (hit(idx_q, `VTF_IDX_ACT_START))
				timing_q.activeStart <= wdata;
			if (hit(idx_q, `VTF_IDX_ACT_END))
				timing_q.activeEnd <= wdata;
			if (hit(idx_q, `VTF_IDX_FIELD))
				timing_q.fieldLines <= wdata;
			if (hit(idx_q, `VTF_IDX_VSYNC))
				timing_q.vsyncLines <= wdata;
		end
	end

	assign timing          = timing_q;
	// whole lines above the half bit
	assign wholeFieldLines = timing_q.fieldLines[`VTF_REG_W-1:`VTF_HALF_BIT+1];
	assign interlaced      = timing_q.fieldLines[`VTF_HALF_BIT];

	// ==========================================
	// ten-field identification pulse

	// pulse ends at next line or field
	always_ff @(posedge clk)
	begin
		if (rst)
			pulse_q <= 1'b0;
		else if (ce)
		begin
			if (tenFieldStart)
				pulse_q <= 1'b1;
			else if (stretch_q ? fieldStart : lineStart)
				pulse_q <= 1'b0;
		end
	end

	assign tenFieldIdPulse = pulse_q;

	// ==========================================
	// assertions

	default clocking cb @(posedge clk);
	endclocking

	sequence s_addr;
		addrPhase && (state_q != VTF_WAIT);
	endsequence

	sequence s_wait;
		ce && !hreadyout;
	endsequence

	a_bus_wait_state: assert property (disable iff (rst) s_addr |=> !hreadyout)
		else $error("no wait state after address phase");

	a_bus_data_phase: assert property (disable iff (rst) s_addr ##1 s_wait |=> hreadyout)
		else $error("data phase longer than one wait state");

	a_custom_hold: assert property (disable iff (rst) ce && custom_q && !commit |=> $stable(timing_q))
		else $error("timing changed in custom mode without a write");

	a_preset_load: assert property (disable iff (rst) ce && !custom_q |=> timing_q == $past(presetTiming))
		else $error("preset timing not loaded");

	a_host_code: assert property (disable iff (rst) ce && hostSel_q |=> activeStandardCode == $past(hostCode_q))
		else $error("host code not selected");

	a_pin_code: assert property (disable iff (rst) ce && !hostSel_q |=> activeStandardCode == $past(pinStandardCode))
		else $error("pin code not selected");

	a_host_reset: assert property (rst |=> hostCode_q == `VTF_RESET_CODE && !hostSel_q && !stretch_q)
		else $error("control not cleared by reset");

	a_pulse_line: assert property (disable iff (rst)
		ce && !stretch_q && pulse_q && lineStart && !tenFieldStart |=> !tenFieldIdPulse)
		else $error("unstretched pulse outlived its line");

	a_pulse_field: assert property (disable iff (rst)
		ce && stretch_q && pulse_q && lineStart && !fieldStart && !tenFieldStart |=> tenFieldIdPulse)
		else $error("stretched pulse ended before field end");

	a_half_line: assert property (disable iff (rst)
		ce && !custom_q |=> interlaced == $past(presetTiming.fieldLines[`VTF_HALF_BIT])
			&& wholeFieldLines == $past(presetTiming.fieldLines[`VTF_REG_W-1:`VTF_HALF_BIT+1]))
		else $error("field line split wrong");

	// custom flag must track the selected code, or software writes would be lost
	a_custom_flag: assert property (disable iff (rst)
		ce |=> customMode == ($past(codeSel) == `VTF_CODE_CUSTOM))
		else $error("custom flag does not match selected code");

	a_line_write: assert property (disable iff (rst)
		commit && custom_q && hit(idx_q, `VTF_IDX_LINE) |=> timing_q.lineClocks == $past(wdata))
		else $error("custom line length write lost");

	a_field_write: assert property (disable iff (rst)
		commit && custom_q && hit(idx_q, `VTF_IDX_FIELD) |=> timing_q.fieldLines == $past(wdata))
		else $error("custom field line write lost");

	a_host_write: assert property (disable iff (rst)
		commit && hit(idx_q, `VTF_IDX_HOST) |=> hostCode_q == $past(wdata[`VTF_CODE_W-1:0]))
		else $error("host code write lost");

	a_pulse_set: assert property (disable iff (rst) ce && tenFieldStart |=> tenFieldIdPulse)
		else $error("pulse not started");

	a_pulse_hold: assert property (disable iff (rst)
		ce && !tenFieldStart && !lineStart && !fieldStart |=> $stable(tenFieldIdPulse))
		else $error("pulse changed without an event");

	// clock enable low must freeze everything, events included
	a_pulse_freeze: assert property (disable iff (rst) !ce |=> $stable(tenFieldIdPulse))
		else $error("pulse moved while clock enable low");

	a_code_freeze: assert property (disable iff (rst)
		!ce |=> $stable(activeStandardCode) && $stable(timing_q))
		else $error("code or timing moved while clock enable low");

endmodule

// ---- video_timing_format_config_test.sv ----
`timescale 1ns/10ps
`include "vtf_cfg.svh"

module video_timing_format_config_test;
	import vtf_pkg::*;
	logic                 clk;
	logic                 ce;
	logic                 rst;
	logic                 hsel;
	logic                 hwrite;
	logic                 hreadyout;
	logic                 hresp;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic [31:0]          haddr;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic [31:0]          q;
	logic [5:0]           pinStandardCode;
	logic [5:0]           activeStandardCode;
	logic                 customMode;
	logic                 interlaced;
	logic [14:0]          wholeFieldLines;
	logic                 tenFieldIdPulse;
	logic [2:0]           evt;
	vtf_timing_t          presetTiming;
	vtf_timing_t          timing;
	logic [15:0]          vals [6];
	int                   fail_count;
	int                   compares;
	localparam vtf_timing_t P = {16'h0898, 16'h002C, 16'h00C0, 16'h0840, 16'h0465, 16'h000A};

	vtf_top u_dut
	(
		.clk                (clk),
		.rst                (rst),
		.ce                 (ce),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hwdata             (hwdata),
		.hready             (hreadyout),
		.hreadyout          (hreadyout),
		.hrdata             (hrdata),
		.hresp              (hresp),
		.pinStandardCode    (pinStandardCode),
		.presetTiming       (presetTiming),
		.lineStart          (evt[0]),
		.fieldStart         (evt[1]),
		.tenFieldStart      (evt[2]),
		.activeStandardCode (activeStandardCode),
		.customMode         (customMode),
		.interlaced         (interlaced),
		.wholeFieldLines    (wholeFieldLines),
		.timing             (timing),
		.tenFieldIdPulse    (tenFieldIdPulse)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================
	// shared tasks
	task automatic stop_test;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// bounded wait, a hang ends the run
	task automatic waitRdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			fail_count++;
			stop_test();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {22'h000000, idx, 2'b00};
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waitRdy();
		q = hrdata;
	endtask

	// one-cycle event pulse, output looked at after the sampling edge
	task automatic ev(input logic [2:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 3'h0;
		#1;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset;
		bus(0, `VTF_IDX_CTRL, 0);
		chk(q, 32'h00000000, "ctrl reset");
		bus(0, `VTF_IDX_HOST, 0);
		chk(q, 32'h00000000, "host reset");
		chk(hresp, 1'b0, "okay response");
		$display("test reset done");
	endtask

	task automatic t_preset;
		chk(activeStandardCode, 6'h05, "pin code used");
		chk(timing, P, "preset loaded");
		bus(1, `VTF_IDX_LINE, 32'h00001234);
		bus(0, `VTF_IDX_LINE, 0);
		chk(q, {16'h0000, P.lineClocks}, "line read-only");
		bus(0, `VTF_IDX_VSYNC, 0);
		chk(q, {16'h0000, P.vsyncLines}, "vsync preset");
		$display("test preset done");
	endtask

	task automatic t_host;
		bus(1, `VTF_IDX_HOST, 32'h0000003E);
		settle();
		chk(activeStandardCode, 6'h05, "host code unused");
		bus(1, `VTF_IDX_CTRL, 32'h00000012);
		settle();
		chk({customMode, activeStandardCode}, 7'h7E, "host code used");
		@(posedge clk);
		pinStandardCode <= 6'h11;
		settle();
		chk(activeStandardCode, 6'h3E, "pins ignored");
		bus(0, `VTF_IDX_HOST, 0);
		chk(q, 32'h0000003E, "host readback");
		bus(0, `VTF_IDX_CTRL, 0);
		chk(q, 32'h00000012, "ctrl readback");
		bus(0, 8'h54, 0);
		chk(q, 32'h00000000, "unmapped read");
		$display("test host done");
	endtask

	task automatic t_custom;
		vals = '{16'h0672, 16'h0028, 16'h0104, 16'h0604, 16'h020D, 16'h0005};
		for (int i = 0; i < 6; i++)
		begin
			bus(1, `VTF_IDX_LINE + i[7:0], {16'h0000, vals[i]});
			bus(0, `VTF_IDX_LINE + i[7:0], 0);
			chk(q, {16'h0000, vals[i]}, "custom readback");
		end
		#1;
		chk(timing, {vals[0], vals[1], vals[2], vals[3], vals[4], vals[5]}, "custom used");
		chk({interlaced, wholeFieldLines}, 16'h8106, "262.5 lines");
		bus(1, `VTF_IDX_FIELD, 32'h0000020C);
		#1;
		chk({interlaced, wholeFieldLines}, 16'h0106, "262 lines");
		// host off: pins pick a preset again, stretch stays on
		bus(1, `VTF_IDX_CTRL, 32'h00000010);
		settle();
		chk({customMode, timing}, {1'b0, P}, "preset reloaded");
		$display("test custom done");
	endtask

	task automatic t_pulse;
		ev(3'b100);
		chk(tenFieldIdPulse, 1'b1, "pulse start");
		ev(3'b001);
		chk(tenFieldIdPulse, 1'b1, "stretched over line");
		ev(3'b010);
		chk(tenFieldIdPulse, 1'b0, "ends at field");
		bus(1, `VTF_IDX_CTRL, 32'h00000000);
		ev(3'b100);
		chk(tenFieldIdPulse, 1'b1, "pulse start");
		ev(3'b001);
		chk(tenFieldIdPulse, 1'b0, "ends at line");
		// clock enable low: a start event must not be taken
		@(posedge clk);
		ce <= 1'b0;
		ev(3'b100);
		chk(tenFieldIdPulse, 1'b0, "frozen by clock enable");
		@(posedge clk);
		ce <= 1'b1;
		ev(3'b100);
		chk(tenFieldIdPulse, 1'b1, "runs again after enable");
		$display("test pulse done");
	endtask

	initial
	begin
		fail_count = 0;
		compares = 0;
		rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		evt = 3'h0;
		pinStandardCode = 6'h05;
		presetTiming = P;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		settle();
		t_reset();
		t_preset();
		t_host();
		t_custom();
		t_pulse();
		stop_test();
	end
endmodule
